// ==== rtl/sbcsm_bank.sv ====
// per-bank command state machine of a two-bank synchronous dram
// Summary of operation
// - idle: deselect, no-op, halt do nothing, or power-down when clock enable drops
// - read burst continues on deselect/no-op, then row active
// - halt during read cuts burst, bank row active
// - read during read restarts burst at new column
// - write during read stops read, starts write burst
// - precharge during read ends burst then closes row
// - write burst continues on deselect/no-op, then write recovery
// - halt during write stops write data, bank row active
// - read during write cuts write, starts read burst
// - write during write restarts write burst at new column
// - precharge during write ends burst then closes row
// - read with auto-close completes, then precharges by itself
// - halted read keeps output driven until column latency has elapsed
// - power-down starts on clock enable falling, lasts while it stays low
`timescale 1ns/100ps
`include "sbcsm_cfg.svh"

module sbcsm_bank
    import sbcsm_pkg::*;
#(
    parameter logic BANK_ID = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // command pins
    input wire logic cke,
    input wire sbcsm_pins_type pins,
    // programmed burst length in beats (1..15) and column latency (2 or 3)
    input wire logic [3:0] burst_len,
    input wire logic [1:0] cas_latency,
    // bank status
    output sbcsm_state_type bank_state,
    output logic power_down,
    output logic dq_drive,
    output logic write_accept,
    // one-cycle event pulses
    output logic illegal_cmd,
    output logic refresh_start,
    output logic self_refresh_start,
    output logic config_load
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset release and command decode

    logic rst_meta;
    logic rst_sync;

    // release is synchronised, assertion stays asynchronous
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // pin pattern to command, used for the live command and the checks
    function automatic sbcsm_cmd_type decode(input sbcsm_pins_type p);
        logic [2:0] rcw;
        rcw = {p.ras_n, p.cas_n, p.we_n};
        if (p.cs_n) begin
            decode = chip_unselected_cmd;
        end else begin
            unique case (rcw)
                3'b111: decode = idle_cycle_cmd;
                3'b110: decode = burst_halt_cmd;
                3'b101: decode = fetch_cmd;
                3'b100: decode = store_cmd;
                3'b011: decode = row_open_cmd;
                3'b010: decode = close_cmd;
                3'b001: decode = refresh_cmd;
                3'b000: decode = config_load_cmd;
            endcase
        end
    endfunction : decode

    sbcsm_cmd_type cmd;
    logic mine;
    logic close_me;

    assign cmd = decode(pins);
    assign mine = (pins.bank_select_bit == BANK_ID);
    // precharge with the auto-close bit high closes both banks
    assign close_me = (cmd == close_cmd) && (mine || pins.autoclose_select_bit);

    ////////////////////////////////////////////////////////////////////////////////
    // bank state machine

    sbcsm_state_type state;
    sbcsm_state_type next_state;
    logic [`SBCSM_CNT_W-1:0] cnt;
    logic [`SBCSM_CNT_W-1:0] next_cnt;
    logic cke_prev;
    logic next_power_down;
    logic next_illegal;
    logic next_ref;
    logic next_sref;
    logic next_cfg;
    logic rd_hit;
    logic wr_hit;

    assign rd_hit = (cmd == fetch_cmd) && mine;
    assign wr_hit = (cmd == store_cmd) && mine;

    // bursts and recovery count down; an interrupting read, write or precharge reloads the count
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_illegal = 1'b0;
        next_ref = 1'b0;
        next_sref = 1'b0;
        next_cfg = 1'b0;
        // power-down is entered only on the falling edge of clock enable
        next_power_down = !cke && (power_down || cke_prev);
        if (cke) begin
            unique case (state)
                st_idle: begin
                    if ((cmd == row_open_cmd) && mine) begin
                        next_state = st_active;
                    end else if (cmd == refresh_cmd) begin
                        next_ref = 1'b1;
                    end else if (cmd == config_load_cmd) begin
                        next_cfg = 1'b1;
                    end else if (rd_hit || wr_hit) begin
                        next_illegal = 1'b1;
                    end
                    // deselect, no-op and halt leave the bank idle
                end
                st_active: begin
                    if (rd_hit) begin
                        next_state = pins.autoclose_select_bit ? st_fetch_ac : st_fetch;
                        next_cnt = burst_len;
                    end else if (wr_hit) begin
                        next_state = st_store;
                        next_cnt = burst_len;
                    end else if (close_me) begin
                        next_state = st_prech;
                        next_cnt = 4'(`SBCSM_PRECH_CYCLES);
                    end else if (((cmd == row_open_cmd) && mine) || (cmd == refresh_cmd)
                                 || (cmd == config_load_cmd)) begin
                        next_illegal = 1'b1;
                    end
                end
                st_fetch, st_store: begin
                    if (rd_hit) begin
                        // restart from the new column
                        next_state = pins.autoclose_select_bit ? st_fetch_ac : st_fetch;
                        next_cnt = burst_len;
                    end else if (wr_hit) begin
                        next_state = st_store;
                        next_cnt = burst_len;
                    end else if (cmd == burst_halt_cmd) begin
                        next_state = st_active;
                    end else if (close_me) begin
                        next_state = st_prech;
                        next_cnt = 4'(`SBCSM_PRECH_CYCLES);
                    end else if (((cmd == row_open_cmd) && mine) || (cmd == refresh_cmd)
                                 || (cmd == config_load_cmd)) begin
                        next_illegal = 1'b1;
                    end else if (cnt <= 4'h1) begin
                        // burst ran out: read to active, write to recovery
                        next_state = (state == st_fetch) ? st_active : st_wrec;
                        next_cnt = (state == st_fetch) ? 4'h0 : 4'(`SBCSM_WREC_CYCLES);
                    end else begin
                        next_cnt = cnt - 4'h1;
                    end
                end
                st_fetch_ac: begin
                    // everything but deselect/no-op and other-bank read, write, activate or single-bank precharge is refused here
                    if (rd_hit || wr_hit || close_me || (cmd == burst_halt_cmd)
                        || ((cmd == row_open_cmd) && mine) || (cmd == refresh_cmd)
                        || (cmd == config_load_cmd)) begin
                        next_illegal = 1'b1;
                    end
                    if (cnt <= 4'h1) begin
                        next_state = st_prech;
                        next_cnt = 4'(`SBCSM_PRECH_CYCLES);
                    end else begin
                        next_cnt = cnt - 4'h1;
                    end
                end
                st_wrec: begin
                    if (cnt <= 4'h1) begin
                        next_state = st_active;
                    end else begin
                        next_cnt = cnt - 4'h1;
                    end
                end
                st_prech: begin
                    if (cnt <= 4'h1) begin
                        next_state = st_idle;
                    end else begin
                        next_cnt = cnt - 4'h1;
                    end
                end
                default: begin
                    next_state = st_idle;
                    next_cnt = 4'h0;
                end
            endcase
        end else if (cke_prev && (state == st_idle) && (cmd == refresh_cmd)) begin
            next_sref = 1'b1;
        end
        // clock enable low freezes the bank: power-down or clock suspend
    end

    // bank state registers
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= st_idle;
            cnt <= 4'h0;
            cke_prev <= 1'b0;
            power_down <= 1'b0;
            illegal_cmd <= 1'b0;
            refresh_start <= 1'b0;
            self_refresh_start <= 1'b0;
            config_load <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cke_prev <= cke;
            power_down <= next_power_down;
            illegal_cmd <= next_illegal;
            refresh_start <= next_ref;
            self_refresh_start <= next_sref;
            config_load <= next_cfg;
        end
    end

    assign bank_state = state;

    ////////////////////////////////////////////////////////////////////////////////
    // data strobes and column latency

    logic [`SBCSM_LAT_PIPE-1:0] lat_pipe;
    logic [`SBCSM_LAT_PIPE-1:0] next_lat_pipe;
    logic next_dq_drive;
    logic next_write_accept;

    // a halted read still drains the latency pipe, so data stops late
    always_comb begin
        next_lat_pipe = {lat_pipe[`SBCSM_LAT_PIPE-2:0],
                         cke && ((state == st_fetch) || (state == st_fetch_ac))};
        next_dq_drive = (cas_latency == 2'h3) ? lat_pipe[1] : lat_pipe[0];
        next_write_accept = cke && (state == st_store);
    end

    // strobe registers
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            lat_pipe <= '0;
            dq_drive <= 1'b0;
            write_accept <= 1'b0;
        end else begin
            lat_pipe <= next_lat_pipe;
            dq_drive <= next_dq_drive;
            write_accept <= next_write_accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    chk_idle_stays: assert property (@(posedge clk) disable iff (!rst_sync)
        (state == st_idle && cke && !(cmd == row_open_cmd && mine)) |=> state == st_idle)
        else $error("idle bank left idle without activate");
    chk_read_end: assert property (@(posedge clk) disable iff (!rst_sync)
        (state == st_fetch && cke && cnt == 4'h1
         && (cmd == idle_cycle_cmd || cmd == chip_unselected_cmd))
        |=> state == st_active)
        else $error("finished read did not return to row active");
    chk_halt_read: assert property (@(posedge clk) disable iff (!rst_sync)
        (state == st_fetch && cke && cmd == burst_halt_cmd) |=> state == st_active)
        else $error("halt did not end read burst");
    chk_read_restart: assert property (@(posedge clk) disable iff (!rst_sync)
        ((state == st_fetch || state == st_store) && cke && rd_hit)
        |=> (state == st_fetch || state == st_fetch_ac) && cnt == $past(burst_len))
        else $error("read did not restart burst");
    chk_write_start: assert property (@(posedge clk) disable iff (!rst_sync)
        ((state == st_fetch || state == st_store) && cke && wr_hit)
        |=> state == st_store ##1 write_accept || !cke)
        else $error("write did not start burst");
    chk_close_burst: assert property (@(posedge clk) disable iff (!rst_sync)
        ((state == st_fetch || state == st_store) && cke && close_me)
        |=> state == st_prech)
        else $error("precharge did not close row");
    chk_write_rec: assert property (@(posedge clk) disable iff (!rst_sync)
        (state == st_store && cke && cnt == 4'h1
         && (cmd == chip_unselected_cmd || cmd == idle_cycle_cmd))
        |=> state == st_wrec)
        else $error("finished write skipped recovery");
    chk_autoclose: assert property (@(posedge clk) disable iff (!rst_sync)
        (state == st_fetch_ac && cke && cnt == 4'h1) |=> state == st_prech)
        else $error("auto-close read did not precharge");
    chk_ac_illegal: assert property (@(posedge clk) disable iff (!rst_sync)
        (state == st_fetch_ac && cke && (rd_hit || cmd == burst_halt_cmd)) |=> illegal_cmd)
        else $error("command in auto-close read not flagged");
    chk_halt_latency: assert property (@(posedge clk) disable iff (!rst_sync)
        // a beat seen in read state reaches the pins three edges later at latency three
        (state == st_fetch && cke && cas_latency == 2'h3) ##1 $stable(cas_latency)
        |-> ##2 dq_drive)
        else $error("output stopped before latency elapsed");
    chk_pd_entry: assert property (@(posedge clk) disable iff (!rst_sync)
        (cke_prev && !cke) |=> power_down)
        else $error("power-down not entered on falling clock enable");

    cov_read_burst: cover property (@(posedge clk) disable iff (!rst_sync)
        state == st_fetch ##1 state == st_active);
    cov_write_rec: cover property (@(posedge clk) disable iff (!rst_sync)
        state == st_store ##1 state == st_wrec);
    cov_ac_close: cover property (@(posedge clk) disable iff (!rst_sync)
        state == st_fetch_ac ##1 state == st_prech);
    cov_power_down: cover property (@(posedge clk) disable iff (!rst_sync)
        state == st_idle && power_down);

endmodule : sbcsm_bank

// ==== rtl/sbcsm_cfg.svh ====
// constants of the per-bank sdram command state machine
`ifndef SBCSM_CFG_SVH
`define SBCSM_CFG_SVH
`define SBCSM_CLK_PERIOD_NS 100
`define SBCSM_TDPL_NS 20
`define SBCSM_TRP_NS 20
`define SBCSM_WREC_CYCLES (((`SBCSM_TDPL_NS + `SBCSM_CLK_PERIOD_NS - 1) / `SBCSM_CLK_PERIOD_NS) < 1 ? 1 : ((`SBCSM_TDPL_NS + `SBCSM_CLK_PERIOD_NS - 1) / `SBCSM_CLK_PERIOD_NS))
`define SBCSM_PRECH_CYCLES (((`SBCSM_TRP_NS + `SBCSM_CLK_PERIOD_NS - 1) / `SBCSM_CLK_PERIOD_NS) < 1 ? 1 : ((`SBCSM_TRP_NS + `SBCSM_CLK_PERIOD_NS - 1) / `SBCSM_CLK_PERIOD_NS))
`define SBCSM_CNT_W 4
`define SBCSM_LAT_PIPE 3
`endif

// ==== rtl/sbcsm_pkg.sv ====
// types of the per-bank sdram command state machine
package sbcsm_pkg;
    // decoded command on the control pins
    typedef enum logic [3:0] {
        chip_unselected_cmd = 4'h0,
        idle_cycle_cmd = 4'h1,
        burst_halt_cmd = 4'h2,
        fetch_cmd = 4'h3,
        store_cmd = 4'h4,
        row_open_cmd = 4'h5,
        close_cmd = 4'h6,
        refresh_cmd = 4'h7,
        config_load_cmd = 4'h8
    } sbcsm_cmd_type;

    // bank states, one-hot
    typedef enum logic [6:0] {
        st_idle = 7'h01,
        st_active = 7'h02,
        st_fetch = 7'h04,
        st_store = 7'h08,
        st_fetch_ac = 7'h10,
        st_wrec = 7'h20,
        st_prech = 7'h40
    } sbcsm_state_type;

    // control pins sampled on the rising edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank_select_bit;
        logic autoclose_select_bit;
    } sbcsm_pins_type;
endpackage : sbcsm_pkg

// ==== verification/sbcsm_ctrl_model.sv ====
// behavioural memory controller driving the command pins of one bank
`timescale 1ns/100ps

module sbcsm_ctrl_model
    import sbcsm_pkg::*;
(
    // state of the bank being driven
    input wire sbcsm_state_type bank_state,
    // command pins toward the bank
    output sbcsm_pins_type pins
);
    ////////////////////////////////////////////////////////////////////////////////
    // raised only by a scenario that wants the bank to see a forbidden command
    logic allow_bad = 1'b0;

    // start deselected
    initial begin
        pins = 6'h3c;
    end

    // drive one command just after a falling edge; it stands until the next call
    task automatic put(input sbcsm_cmd_type c, input logic bk, input logic ac);
        logic bad;
        logic [3:0] code;
        // cs, ras, cas, we happen to equal eight minus the command code
        code = 4'h8 - 4'(c);
        bad = bank_state == st_fetch_ac && code < 4'h7;
        bad |= bank_state == st_idle && c inside {fetch_cmd, store_cmd};
        bad |= bank_state == st_active && code < 4'h4 && code != 4'h2;
        // a sane controller idles rather than break the command table
        if (bad && !allow_bad) begin
            code = 4'h7;
        end
        // lines of a deselected cycle mean nothing, so they flip to catch a stale read
        if (code[3]) begin
            pins = {1'b1, ~pins[4:0]};
        end else begin
            pins = {code, bk, ac};
        end
    endtask : put
endmodule : sbcsm_ctrl_model

// ==== verification/tb_sbcsm_bank.sv ====
// self-checking bench for the per-bank sdram command state machine
`timescale 1ns/100ps

module tb_sbcsm_bank
    import sbcsm_pkg::*;
;
    // bank one is served, so a bank bit stuck at zero shows up
    localparam logic BK = 1'b1;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cke = 1'b1;
    logic [3:0] burst_len = 4'h4;
    logic [1:0] cas_latency = 2'h2;
    sbcsm_pins_type pins;
    sbcsm_state_type bank_state;
    logic power_down, dq_drive, write_accept;
    logic illegal_cmd, refresh_start, self_refresh_start, config_load;
    int checked = 0;
    int miscompares = 0;

    sbcsm_bank #(.BANK_ID(BK)) dut (.clk(clk), .nrst(nrst), .cke(cke), .pins(pins),
        .burst_len(burst_len), .cas_latency(cas_latency), .bank_state(bank_state),
        .power_down(power_down), .dq_drive(dq_drive), .write_accept(write_accept),
        .illegal_cmd(illegal_cmd), .refresh_start(refresh_start),
        .self_refresh_start(self_refresh_start), .config_load(config_load));
    sbcsm_ctrl_model ctrl (.bank_state(bank_state), .pins(pins));

    // 10 mhz clock
    initial begin
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare one observed value with its expectation
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // present a command and let the edge that takes it pass
    task automatic step(input sbcsm_cmd_type c, input logic ac = 1'b0, input logic bk = BK);
        ctrl.put(c, bk, ac);
        @(negedge clk);
    endtask : step

    // command, then the bank state it leads to
    task automatic go(input sbcsm_cmd_type c, input sbcsm_state_type s,
                      input logic ac = 1'b0, input logic bk = BK);
        step(c, ac, bk);
        check(bank_state, s);
    endtask : go

    // a forbidden command is only flagged and leaves the state alone
    task automatic bad(input sbcsm_cmd_type c, input sbcsm_state_type s);
        ctrl.allow_bad = 1'b1;
        go(c, s);
        check(illegal_cmd, 1'b1);
        ctrl.allow_bad = 1'b0;
    endtask : bad

    // counts, verdict, end of run
    task automatic give_verdict;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // idle commands, pulses, power-down and self refresh entry
    task automatic s_idle;
        go(chip_unselected_cmd, st_idle);
        go(idle_cycle_cmd, st_idle);
        go(burst_halt_cmd, st_idle);
        bad(fetch_cmd, st_idle);
        bad(store_cmd, st_idle);
        go(refresh_cmd, st_idle);
        check(refresh_start, 1'b1);
        go(config_load_cmd, st_idle);
        check({refresh_start, config_load}, 12'h001);
        cke = 1'b0;
        go(idle_cycle_cmd, st_idle);
        repeat (3) step(idle_cycle_cmd);
        check(power_down, 1'b1);
        cke = 1'b1;
        step(idle_cycle_cmd);
        check(power_down, 1'b0);
        cke = 1'b0;
        step(refresh_cmd);
        check(self_refresh_start, 1'b1);
        cke = 1'b1;
        go(idle_cycle_cmd, st_idle);
    endtask : s_idle

    // read burst run out or halted after two beats; data trails by the latency
    task automatic s_read(input logic [1:0] cl, input logic halt);
        logic [11:0] rd, dq, rd_exp;
        cas_latency = cl;
        rd_exp = halt ? 12'h003 : 12'h00f;
        go(row_open_cmd, st_active);
        step(fetch_cmd);
        for (int j = 0; j < 12; j++) begin
            rd[j] = bank_state === st_fetch;
            dq[j] = dq_drive;
            step(halt && j == 1 ? burst_halt_cmd : idle_cycle_cmd);
        end
        check(rd, rd_exp);
        check(dq, rd_exp << cl);
        go(close_cmd, st_prech);
        go(idle_cycle_cmd, st_idle);
    endtask : s_read

    // second burst one cycle into the first; it must last a full burst of its own
    task automatic s_pair(input sbcsm_cmd_type a, input sbcsm_cmd_type b, input logic ac,
                          input sbcsm_state_type s, input sbcsm_state_type s_end);
        go(row_open_cmd, st_active);
        step(a);
        go(b, s, ac);
        repeat (3) step(idle_cycle_cmd);
        check(bank_state, s);
        go(idle_cycle_cmd, s_end);
        step(idle_cycle_cmd);
        step(close_cmd, 1'b1);
        go(idle_cycle_cmd, st_idle);
    endtask : s_pair

    // other bank, write halt, precharge cuts, forbidden commands in row active
    task automatic s_cut;
        go(row_open_cmd, st_active);
        go(fetch_cmd, st_active, 1'b0, ~BK);
        go(store_cmd, st_store);
        check(write_accept, 1'b0);
        go(idle_cycle_cmd, st_store);
        check(write_accept, 1'b1);
        go(burst_halt_cmd, st_active);
        // the beat before the halt is still reported one cycle late
        check(write_accept, 1'b1);
        go(idle_cycle_cmd, st_active);
        check(write_accept, 1'b0);
        go(store_cmd, st_store);
        go(close_cmd, st_prech);
        go(idle_cycle_cmd, st_idle);
        go(row_open_cmd, st_active);
        go(fetch_cmd, st_fetch);
        go(close_cmd, st_prech, 1'b1, ~BK);
        go(idle_cycle_cmd, st_idle);
        go(row_open_cmd, st_active);
        bad(row_open_cmd, st_active);
        bad(refresh_cmd, st_active);
        bad(config_load_cmd, st_active);
        go(close_cmd, st_prech);
        go(idle_cycle_cmd, st_idle);
    endtask : s_cut

    // self-closing read refuses a halt, then closes the row by itself
    task automatic s_auto;
        go(row_open_cmd, st_active);
        go(fetch_cmd, st_fetch_ac, 1'b1);
        bad(burst_halt_cmd, st_fetch_ac);
        repeat (2) step(idle_cycle_cmd);
        check(bank_state, st_fetch_ac);
        go(idle_cycle_cmd, st_prech);
        go(idle_cycle_cmd, st_idle);
    endtask : s_auto

    ////////////////////////////////////////////////////////////////////////////////
    // cut a hang short
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    // reset, then every scenario in turn
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        check(bank_state, st_idle);
        s_idle();
        for (int k = 0; k < 4; k++) begin
            s_read(2'(2 + k[0]), k[1]);
        end
        s_pair(fetch_cmd, fetch_cmd, 1'b0, st_fetch, st_active);
        s_pair(fetch_cmd, store_cmd, 1'b0, st_store, st_wrec);
        s_pair(store_cmd, fetch_cmd, 1'b0, st_fetch, st_active);
        s_pair(store_cmd, store_cmd, 1'b0, st_store, st_wrec);
        s_pair(store_cmd, fetch_cmd, 1'b1, st_fetch_ac, st_prech);
        s_cut();
        s_auto();
        give_verdict();
    end
endmodule : tb_sbcsm_bank
